//--- hw/cls_pkg.sv
// Constants, register map and encodings for the camera link serializer core.
// Assumes a 20 MHz APB clock; the core and the testbench refer to names here.
package cls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 50;     // APB clock period
  localparam int PCLK_LOSS_NS   = 1000;   // Pixel clock declared lost after this
  localparam int PCLK_LOSS_CYC  = (PCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GPIO_DELTA_NS  = 25000;  // Allowed arrival spread, forwarded outputs
  localparam int GPIO_DELTA_CYC = GPIO_DELTA_NS / CLK_PERIOD_NS;
  localparam int OSC_FULL_DIV   = 2;      // Internal oscillator tick, full rate
  localparam int OSC_LOW_DIV    = 4;      // Internal oscillator tick, lower rate

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CFG      = 8'h03;
  localparam logic [7:0] IDX_CRC_A    = 8'h0a;
  localparam logic [7:0] IDX_CRC_B    = 8'h0b;
  localparam logic [7:0] IDX_GPO      = 8'h0d;
  localparam logic [7:0] IDX_CTL_TX   = 8'h0e;
  localparam logic [7:0] IDX_STATUS   = 8'h0f;
  localparam logic [7:0] IDX_CTL_RX   = 8'h10;
  localparam logic [7:0] IDX_OSC      = 8'h14;

  // Reset values
  localparam logic [7:0] CFG_RST      = 8'h01;
  localparam logic [7:0] OSC_RST      = 8'h00;
  localparam logic [7:0] GPO_RST      = 8'h00;

  // Field positions
  localparam int CFG_EDGE_BIT  = 0;       // tx_clock_edge_select
  localparam int CFG_FORCE_BIT = 1;       // Stay on internal oscillator
  localparam int CFG_MODE_LO   = 2;       // Payload mode, two bits
  localparam int OSC_RATE_LO   = 1;       // Oscillator rate, two bits
  localparam int GPO_SEL_LO    = 4;       // Remote select per pin

  // Payload modes
  localparam logic [1:0] MODE_12LF = 2'h0;
  localparam logic [1:0] MODE_12HF = 2'h1;
  localparam logic [1:0] MODE_10   = 2'h2;

  // Oscillator rate codes
  localparam logic [1:0] OSC_FULL  = 2'h1;
  localparam logic [1:0] OSC_RSVD  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Forward frame layout
  localparam int FRAME_W    = 28;
  localparam int PAYLOAD_W  = 24;
  localparam int CTL_LO     = 24;         // Control valid bit 25, data bit 24
  localparam int INV_BIT    = 26;         // DC balance inversion flag
  localparam int PAR_BIT    = 27;         // Even parity over bits 26:0
  localparam logic [27:0] FRAME_IDLE_HIGH = 28'hfffffff;

  // Back channel word: remote outputs in 11:8, control byte in 7:0
  localparam int BC_W       = 12;
  localparam int BC_GPIO_LO = 8;
  localparam logic [4:0] CRC_POLY = 5'h13; // x^4 + x + 1

  // Clock source states
  typedef enum logic {CS_OSC, CS_EXT} cls_src_t;

endpackage

//--- hw/cls_scrambler.sv
// Additive scrambler mask generator for the forward payload.
// Assumes one advance request per emitted frame; reset seeds a nonzero state.
`timescale 1ns/10ps
module cls_scrambler #(
  parameter int WIDTH = 24,
  parameter logic [30:0] SEED = 31'h1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             advance,
  // Mask for this frame
  output logic [WIDTH-1:0]      mask
);

  logic [30:0] state_q;   // PRBS31 state
  logic [30:0] state_d;   // State after WIDTH steps

  ////////////////////////////////////////////////////////////////////////////
  // Step x^31 + x^28 + 1 WIDTH times so each frame uses fresh bits
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++) begin
      state_d = {state_d[29:0], state_d[30] ^ state_d[27]};
    end
  end

  // State advances only when a frame leaves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SEED;
    end else if (advance) begin
      state_q <= state_d;
    end
  end

  assign mask = state_q[WIDTH-1:0];

endmodule

//--- hw/cls_serializer_core.sv
// Serializer front end: pixel capture, payload packing, scrambling, DC balance,
// parity, clock source choice, back-channel CRC counting and general outputs.
// Assumes all pins are synchronous to pclk; the analog driver sits downstream.
`timescale 1ns/10ps

// Notes on behaviour
// - Frame is 28 bits with all fields
// - Payload scrambled and DC balanced always
// - 12-bit low mode accepts 14 bits/pixel
// - 12-bit high mode accepts 14 bits/pixel
// - Frame rate is pixel rate /1,/2,/1.5
// - One parity bit; back channel 4-bit CRC
// - CRC errors counted in two byte registers
// - Control bits ride inside every frame
// - Four outputs, remote or local source
// - Output pins never forward inputs onward
// - External oscillator: pin3 in, pin2 half clock
// - Forwarded output latency fixed and small
// - Edge select picks rising or falling
// - No pixel clock: run on internal oscillator
// - Power down low: serial output static high
// - Switch to pixel clock unless forced internal
// - Oscillator rate code 01 full, else lower
module cls_serializer_core (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parallel pixel side
  input  wire logic        pixel_clk_in,
  input  wire logic [11:0] pix_data,
  input  wire logic        line_sync,
  input  wire logic        frame_sync,
  // Static pins
  input  wire logic        power_down_n_pin,
  input  wire logic        ext_osc_mode_pin,
  // Back channel words from the link
  input  wire logic        bc_valid,
  input  wire logic [11:0] bc_word,
  input  wire logic [3:0]  bc_crc,
  // General output pins
  input  wire logic [3:0]  general_output_pin_i,
  output logic      [3:0]  general_output_pin_o,
  output logic      [3:0]  general_output_pin_oe,
  // Forward frame to the line driver
  output logic      [27:0] ser_frame,
  output logic             ser_frame_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic [7:0]  cfg_q, osc_q, gpo_q, ctl_rx_q;  // Software and link registers
  logic [15:0] crc_err_q;                      // Back-channel error count
  logic [7:0]  ctl_tx_q;                       // Control byte being sent
  logic [3:0]  ctl_cnt_q;                      // Bits left to send
  logic        wr_en, rd_en, hit;              // Access qualifiers
  logic [7:0]  idx;                            // Word index
  logic        pd_n;                           // Powered, link enabled

  assign idx     = {2'h0, paddr[7:2]};
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign hit     = idx inside {cls_pkg::IDX_CFG, cls_pkg::IDX_CRC_A, cls_pkg::IDX_CRC_B,
                               cls_pkg::IDX_GPO, cls_pkg::IDX_CTL_TX, cls_pkg::IDX_STATUS,
                               cls_pkg::IDX_CTL_RX, cls_pkg::IDX_OSC};
  assign pready  = 1'b1;                        // Zero wait states
  assign pslverr = psel && penable && !hit;     // Unmapped word refused
  assign pd_n    = power_down_n_pin;

  // Read mux, low byte only
  logic [7:0] rd_byte;
  logic       ext_active;
  assign rd_byte =
    (idx == cls_pkg::IDX_CFG)    ? cfg_q :
    (idx == cls_pkg::IDX_CRC_A)  ? crc_err_q[7:0] :
    (idx == cls_pkg::IDX_CRC_B)  ? crc_err_q[15:8] :
    (idx == cls_pkg::IDX_GPO)    ? gpo_q :
    (idx == cls_pkg::IDX_CTL_TX) ? ctl_tx_q :
    (idx == cls_pkg::IDX_STATUS) ? {5'h0, !pd_n, (ctl_cnt_q != 4'h0), ext_active} :
    (idx == cls_pkg::IDX_CTL_RX) ? ctl_rx_q :
    (idx == cls_pkg::IDX_OSC)    ? osc_q : 8'h00;
  assign prdata = (rd_en && hit) ? {24'h0, rd_byte} : 32'h0;

  // Configuration registers; status and counters are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= cls_pkg::CFG_RST;
      osc_q <= cls_pkg::OSC_RST;
      gpo_q <= cls_pkg::GPO_RST;
    end else if (wr_en) begin
      if (idx == cls_pkg::IDX_CFG) cfg_q <= pwdata[7:0];
      if (idx == cls_pkg::IDX_OSC) osc_q <= pwdata[7:0];
      if (idx == cls_pkg::IDX_GPO) gpo_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock edge detection and capture
  logic       pclk_pix_q;                      // Previous pixel clock sample
  logic       pix_rise, pix_fall, pix_edge, capture;
  logic [1:0] mode;
  assign mode     = cfg_q[cls_pkg::CFG_MODE_LO +: 2];
  assign pix_rise = pixel_clk_in && !pclk_pix_q;
  assign pix_fall = !pixel_clk_in && pclk_pix_q;
  assign pix_edge = pix_rise || pix_fall;
  // Edge select bit 1 = rising, 0 = falling
  assign capture  = (cfg_q[cls_pkg::CFG_EDGE_BIT] ? pix_rise : pix_fall)
                    && ext_active && pd_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pclk_pix_q <= 1'b0;
    else          pclk_pix_q <= pixel_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source: pixel clock when present, else internal oscillator
  cls_pkg::cls_src_t cs_q;
  logic [15:0]       loss_q;                   // Cycles since last pixel edge
  assign ext_active = (cs_q == cls_pkg::CS_EXT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q   <= cls_pkg::CS_OSC;
      loss_q <= 16'h0;
    end else begin
      loss_q <= pix_edge ? 16'h0 : loss_q + 16'h1;
      unique case (cs_q)
        // Edge seen and not forced internal
        cls_pkg::CS_OSC: if (pix_edge && !cfg_q[cls_pkg::CFG_FORCE_BIT])
          cs_q <= cls_pkg::CS_EXT;
        // Clock gone: fall back to oscillator
        cls_pkg::CS_EXT: if (!pix_edge && loss_q >= 16'(cls_pkg::PCLK_LOSS_CYC - 1))
          cs_q <= cls_pkg::CS_OSC;
      endcase
    end
  end

  // Internal oscillator tick; rate code 01 full, others lower
  logic [2:0] osc_cnt_q;
  logic [2:0] osc_div;
  logic       osc_tick;
  assign osc_div  = (osc_q[cls_pkg::OSC_RATE_LO +: 2] == cls_pkg::OSC_FULL)
                    ? 3'(cls_pkg::OSC_FULL_DIV) : 3'(cls_pkg::OSC_LOW_DIV);
  assign osc_tick = !ext_active && pd_n && (osc_cnt_q >= osc_div - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      osc_cnt_q <= 3'h0;
    else if (osc_tick) osc_cnt_q <= 3'h0;
    else               osc_cnt_q <= osc_cnt_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Payload packing per mode; phase counts pixels within a frame group
  logic [1:0]  ph_q;
  logic [13:0] acc_q;                          // Pixel bits carried forward
  logic [13:0] pix14, pix12;
  logic        emit;
  logic [23:0] payload;
  assign pix14 = {frame_sync, line_sync, pix_data};
  assign pix12 = {2'h0, frame_sync, line_sync, pix_data[9:0]};
  // Low mode every pixel, 10-bit every second, high mode two of three
  assign emit  = osc_tick ||
                 (capture && ((mode == cls_pkg::MODE_10)   ? (ph_q == 2'h1) :
                              (mode == cls_pkg::MODE_12HF) ? (ph_q != 2'h0) : 1'b1));
  assign payload =
    !capture                     ? 24'h0 :                           // Idle frame
    (mode == cls_pkg::MODE_10)   ? {acc_q[11:0], pix12[11:0]} :
    (mode == cls_pkg::MODE_12HF) ? ((ph_q == 2'h1) ? {3'h0, acc_q, pix14[13:7]}
                                                   : {3'h0, acc_q[6:0], pix14}) :
                                   {10'h0, pix14};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q  <= 2'h0;
      acc_q <= 14'h0;
    end else if (!ext_active || !pd_n) begin
      ph_q  <= 2'h0;                           // Realign on relock
    end else if (capture) begin
      unique case (mode)
        cls_pkg::MODE_10: begin
          ph_q  <= ph_q ^ 2'h1;
          acc_q <= pix12;
        end
        cls_pkg::MODE_12HF: begin
          ph_q  <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
          acc_q <= (ph_q == 2'h0) ? pix14 : {7'h0, pix14[6:0]};
        end
        default: ph_q <= 2'h0;                 // Low mode and code 11
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forward control channel: one valid bit and one data bit per frame
  logic [1:0] ctl_bits;
  assign ctl_bits = (ctl_cnt_q != 4'h0) ? {1'b1, ctl_tx_q[0]} : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_tx_q  <= 8'h0;
      ctl_cnt_q <= 4'h0;
    end else if (wr_en && idx == cls_pkg::IDX_CTL_TX && ctl_cnt_q == 4'h0) begin
      ctl_tx_q  <= pwdata[7:0];                // Write while busy is ignored
      ctl_cnt_q <= 4'h8;
    end else if (emit && ctl_cnt_q != 4'h0) begin
      ctl_tx_q  <= {1'b0, ctl_tx_q[7:1]};
      ctl_cnt_q <= ctl_cnt_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scramble, DC balance, parity
  logic [23:0] mask, scr, bal;
  logic [4:0]  ones;
  logic        rd_pos_q, inv;                  // Running disparity sign
  logic [26:0] body;

  cls_scrambler #(.WIDTH(cls_pkg::PAYLOAD_W), .SEED(31'h1)) u_scr (
    .pclk    (pclk),
    .presetn (presetn),
    .advance (emit),
    .mask    (mask)
  );

  assign scr  = payload ^ mask;
  assign ones = 5'($countones(scr));
  // Invert when the word would push disparity further the same way
  assign inv  = rd_pos_q ? (ones > 5'd12) : (ones < 5'd12);
  assign bal  = inv ? ~scr : scr;
  assign body = {inv, ctl_bits, bal};

  // Frame register; static high while powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_frame       <= cls_pkg::FRAME_IDLE_HIGH;
      ser_frame_valid <= 1'b0;
      rd_pos_q        <= 1'b0;
    end else if (!pd_n) begin
      ser_frame       <= cls_pkg::FRAME_IDLE_HIGH;
      ser_frame_valid <= 1'b0;
    end else begin
      ser_frame_valid <= emit;
      if (emit) begin
        ser_frame <= {^body, body};
        if (ones != 5'd12) rd_pos_q <= (ones > 5'd12) ^ inv;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Back channel CRC check and error counter
  function automatic logic [3:0] crc4(input logic [11:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      c = (c[3] ^ d[i]) ? ({c[2:0], 1'b0} ^ cls_pkg::CRC_POLY[3:0]) : {c[2:0], 1'b0};
    end
    return c;
  endfunction

  logic crc_ok, crc_bad;
  logic [3:0] remote_q;                        // Remote output values
  assign crc_ok  = bc_valid && (crc4(bc_word) == bc_crc);
  assign crc_bad = bc_valid && !crc_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_err_q <= 16'h0;
      remote_q  <= 4'h0;
      ctl_rx_q  <= 8'h0;
    end else begin
      // Saturates rather than wrapping so a flood stays visible
      if (crc_bad && crc_err_q != 16'hffff) crc_err_q <= crc_err_q + 16'h1;
      if (crc_ok) begin
        remote_q <= bc_word[cls_pkg::BC_GPIO_LO +: 4];
        ctl_rx_q <= bc_word[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General outputs and external oscillator divider
  logic       osc_prev_q, ref_div_q;           // Oscillator sample, half clock
  logic       osc_clock_in;
  logic [3:0] gpo_val;
  assign osc_clock_in = general_output_pin_i[3];
  // Per pin: remote value when selected, else local bit
  assign gpo_val = (gpo_q[cls_pkg::GPO_SEL_LO +: 4] & remote_q) |
                   (~gpo_q[cls_pkg::GPO_SEL_LO +: 4] & gpo_q[3:0]);
  // Pins drive except pin 3 in oscillator mode; pin inputs never reach the link
  assign general_output_pin_o  = ext_osc_mode_pin
                                 ? {1'b0, ref_div_q, gpo_val[1:0]} : gpo_val;
  assign general_output_pin_oe = ext_osc_mode_pin ? 4'h7 : 4'hf;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
      ref_div_q  <= 1'b0;
    end else begin
      osc_prev_q <= osc_clock_in;
      if (ext_osc_mode_pin && osc_clock_in && !osc_prev_q) ref_div_q <= !ref_div_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pd_static_high: assert property (!pd_n |=> ser_frame == cls_pkg::FRAME_IDLE_HIGH
    && !ser_frame_valid) else $error("frame not static high in power down");
  a_frame_even_parity: assert property (ser_frame_valid |-> !(^ser_frame))
    else $error("frame parity wrong");
  a_pin3_input: assert property (ext_osc_mode_pin |-> !general_output_pin_oe[3])
    else $error("pin3 driven in oscillator mode");
  a_ref_half_clock: assert property (ext_osc_mode_pin && osc_clock_in && !osc_prev_q
    |=> general_output_pin_o[2] != $past(general_output_pin_o[2]))
    else $error("divided clock did not toggle");
  a_crc_err_count: assert property (crc_bad && crc_err_q != 16'hffff
    |=> crc_err_q == $past(crc_err_q) + 16'h1) else $error("crc error not counted");
  a_low_mode_rate: assert property (capture && mode == cls_pkg::MODE_12LF && pd_n
    ##1 pd_n |-> ser_frame_valid) else $error("low mode frame missing");
  a_ten_mode_half: assert property (capture && mode == cls_pkg::MODE_10 && ph_q == 2'h0
    |=> !ser_frame_valid) else $error("10-bit frame on first pixel");
  a_falling_only: assert property (ext_active && pd_n && !cfg_q[cls_pkg::CFG_EDGE_BIT]
    && pix_rise && mode == cls_pkg::MODE_12LF |=> !ser_frame_valid)
    else $error("frame on wrong pixel edge");
  a_forced_internal: assert property (cfg_q[cls_pkg::CFG_FORCE_BIT] && !ext_active
    |=> !ext_active) else $error("left oscillator while forced");
  a_remote_latency: assert property (crc_ok && gpo_q[cls_pkg::GPO_SEL_LO] && !wr_en
    ##1 !wr_en |-> general_output_pin_o[0] == $past(bc_word[cls_pkg::BC_GPIO_LO]))
    else $error("remote output late");

  c_ext_entry: cover property (!ext_active ##1 ext_active);
  c_crc_error: cover property (crc_bad);
  c_hf_frame:  cover property (capture && mode == cls_pkg::MODE_12HF && ph_q == 2'h2);
  c_osc_frame: cover property (osc_tick ##1 ser_frame_valid);

endmodule

//--- bench/cls_partner_model.sv
// Far-side model: imager pixel clock and data, back-channel words, oscillator pin.
// Assumes its tasks are called from the bench right after a pclk rising edge.
`timescale 1ns/10ps
module cls_partner_model (
  // Clock
  input  wire logic   pclk,
  // Imager side
  output logic        pixel_clk_in,
  output logic [11:0] pix_data,
  output logic        line_sync,
  output logic        frame_sync,
  // Back channel and oscillator
  output logic        bc_valid,
  output logic [11:0] bc_word,
  output logic [3:0]  bc_crc,
  output logic        osc_clk
);
  int pix_n = 0;  // Pixels sent so far

  // Quiet lines at time zero
  initial begin
    pixel_clk_in = 1'b0;
    pix_data = 12'h0;
    line_sync = 1'b0;
    frame_sync = 1'b0;
    bc_valid = 1'b0;
    bc_word = 12'h0;
    bc_crc = 4'h0;
    osc_clk = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock of four pclk periods; it stands still low between bursts
  task automatic burst(input int n);
    @(posedge pclk);
    repeat (n) begin
      pixel_clk_in <= 1'b1;
      repeat (2) @(posedge pclk);
      pixel_clk_in <= 1'b0;
      pix_data <= pix_n[11:0];
      line_sync <= pix_n[4];  // Line sync toggles once per 16 pixels, frame sync once per 256
      frame_sync <= pix_n[8];
      pix_n++;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Back-channel word; bad flips one CRC bit
  task automatic send_bc(input logic [11:0] w, input logic bad);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 11; i >= 0; i--)
      c = {c[2:0], 1'b0} ^ ((c[3] ^ w[i]) ? 4'h3 : 4'h0);
    @(posedge pclk) bc_valid <= 1'b1;
    bc_word <= w;
    bc_crc <= c ^ {3'h0, bad};
    @(posedge pclk) bc_valid <= 1'b0;
    bc_word <= ~w;  // Released lines never keep the old value
    bc_crc <= ~c;
    repeat (4) @(posedge pclk);  // Spacing keeps remote toggles slow
  endtask

  // One period of the external oscillator
  task automatic osc_pulse();
    @(posedge pclk) osc_clk <= 1'b1;
    repeat (2) @(posedge pclk);
    osc_clk <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the camera link serializer core.
// Assumes cls_partner_model drives the far side; the APB slave answers at once.
`timescale 1ns/10ps
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, v;
  logic        pixel_clk_in, line_sync, frame_sync, bc_valid, osc_clk;
  logic [11:0] pix_data, bc_word;
  logic [3:0]  bc_crc, gp_o, gp_oe, gp_wire;
  logic        power_down_n_pin = 1'b1, ext_osc_mode_pin = 1'b0;
  logic [27:0] ser_frame, prev;
  logic        ser_frame_valid;
  int          miscompares = 0, num_checks = 0, n;

  // Pin level from the design's enables, oscillator where released
  assign gp_wire = (gp_oe & gp_o) | (~gp_oe & {osc_clk, 3'h0});

  always #25 pclk = ~pclk;

  cls_serializer_core cls_serializer_core_i (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .pixel_clk_in, .pix_data, .line_sync,
    .frame_sync, .power_down_n_pin, .ext_osc_mode_pin, .bc_valid, .bc_word, .bc_crc,
    .general_output_pin_i(gp_wire), .general_output_pin_o(gp_o),
    .general_output_pin_oe(gp_oe), .ser_frame, .ser_frame_valid);

  cls_partner_model cls_partner_model_i (.pclk, .pixel_clk_in, .pix_data, .line_sync,
    .frame_sync, .bc_valid, .bc_word, .bc_crc, .osc_clk);

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    if (k == 20) begin
      miscompares++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h0);
    chk(nm, e, rd);
  endtask

  // Counts frames over a window; each frame checked for parity and scrambling
  task automatic count_frames(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (ser_frame_valid === 1'b1) begin
        n++;
        chk("parity", 32'h0, {31'h0, ^ser_frame});
        chk("scrambled", 32'h1, {31'h0, ser_frame !== prev});
        prev = ser_frame;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk("cfg", cls_pkg::IDX_CFG, {24'h0, cls_pkg::CFG_RST});
    rd_chk("osc", cls_pkg::IDX_OSC, {24'h0, cls_pkg::OSC_RST});
    rd_chk("gpo", cls_pkg::IDX_GPO, {24'h0, cls_pkg::GPO_RST});
    apb(1'b0, 8'h01, 8'h0);
    chk("unmapped", 32'h1, {31'h0, er});
  endtask

  task automatic t_power();
    power_down_n_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    count_frames(8);
    chk("pd frames", 32'h0, n);
    chk("pd level", {4'h0, cls_pkg::FRAME_IDLE_HIGH}, {4'h0, ser_frame});
    rd_chk("pd status", cls_pkg::IDX_STATUS, 32'h4);
    power_down_n_pin <= 1'b1;
  endtask

  task automatic t_osc();
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, cls_pkg::IDX_OSC, 8'(c << 1));
      repeat (4) @(posedge pclk);
      count_frames(40);
      chk("osc frames", (c == 1) ? 32'd20 : 32'd10, n);
    end
  endtask

  // Control byte rides lsb first in bits 25:24 of the next eight frames
  task automatic t_ctl();
    logic [7:0] got;
    got = 8'h0;
    apb(1'b1, cls_pkg::IDX_CTL_TX, 8'h5a);
    @(posedge pclk);
    n = 0;
    for (int k = 0; k < 60 && n < 8; k++) begin
      @(posedge pclk);
      if (ser_frame_valid === 1'b1) begin
        n++;
        got = {ser_frame[cls_pkg::CTL_LO], got[7:1]};
        chk("ctl valid", 32'h1, {31'h0, ser_frame[cls_pkg::CTL_LO + 1]});
      end
    end
    if (n != 8) begin
      miscompares++;
      wrap_up();
    end
    chk("ctl byte", 32'h5a, {24'h0, got});
    rd_chk("ctl done", cls_pkg::IDX_STATUS, 32'h0);
  endtask

  task automatic t_pixel();
    logic [1:0] md [3];
    int ex [3];
    md = '{cls_pkg::MODE_12LF, cls_pkg::MODE_10, cls_pkg::MODE_12HF};
    ex = '{12, 6, 8};
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, cls_pkg::IDX_CFG, {4'h0, md[m], 1'b0, m[0]});
      cls_partner_model_i.burst(2);
      apb(1'b0, cls_pkg::IDX_STATUS, 8'h0);
      chk("ext lock", 32'h1, {31'h0, rd[0]});
      fork
        cls_partner_model_i.burst(12);
        count_frames(52);
      join
      chk("pixel frames", ex[m], n);
      repeat (25) @(posedge pclk);
      apb(1'b0, cls_pkg::IDX_STATUS, 8'h0);
      chk("fallback", 32'h0, {31'h0, rd[0]});
    end
    apb(1'b1, cls_pkg::IDX_CFG, 8'h03);
    cls_partner_model_i.burst(3);
    apb(1'b0, cls_pkg::IDX_STATUS, 8'h0);
    chk("forced osc", 32'h0, {31'h0, rd[0]});
  endtask

  task automatic t_backch();
    // Remote select set first so the good word reaches the pins
    apb(1'b1, cls_pkg::IDX_GPO, 8'hf3);
    repeat (3) cls_partner_model_i.send_bc(12'h123, 1'b1);
    cls_partner_model_i.send_bc(12'ha5c, 1'b0);
    apb(1'b1, cls_pkg::IDX_CRC_A, 8'h0);
    rd_chk("count lo", cls_pkg::IDX_CRC_A, 32'h3);
    rd_chk("count hi", cls_pkg::IDX_CRC_B, 32'h0);
    rd_chk("ctl rx", cls_pkg::IDX_CTL_RX, 32'h5c);
    chk("remote out", 32'ha, {28'h0, gp_o});
    apb(1'b1, cls_pkg::IDX_GPO, 8'h03);
    @(posedge pclk);
    chk("local out", 32'h3, {28'h0, gp_o});
    chk("out enable", 32'hf, {28'h0, gp_oe});
  endtask

  task automatic t_extosc();
    ext_osc_mode_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("osc enable", 32'h7, {28'h0, gp_oe});
    v = gp_o[2];
    cls_partner_model_i.osc_pulse();
    chk("half clock", {31'h0, ~v}, {31'h0, gp_o[2]});
    cls_partner_model_i.osc_pulse();
    chk("half clock", {31'h0, v}, {31'h0, gp_o[2]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    prev = 28'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_power();
    t_osc();
    t_ctl();
    t_pixel();
    t_backch();
    t_extosc();
    wrap_up();
  end
endmodule
